/* rtl/cse_core_exec.sv */
// Function
// - watchdog clear zeroes counter and prescaler together
// - watchdog clear sets timeout and powerdown flags
// - call via work pushes pc plus one first
// - call loads pc from latch and work
// - call via work: two cycles, flags untouched
// - complement inverts file register, updates zero
// - dest zero to work, one to file
// - clear file writes zero, sets zero flag
// - clear work writes zero, sets zero flag
// - decrement file by one, updates zero
// - decrement-skip writes result, flags untouched
// - zero result discards next instruction as nop
`timescale 1ns/1ps
`default_nettype none
module cse_core_exec #(
  parameter int STACK_DEPTH = cse_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [cse_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cse_pkg::APB_DW-1:0] pwdata,
  output logic pready,
  output logic [cse_pkg::APB_DW-1:0] prdata,
  output logic pslverr,
  // data register file
  output cse_pkg::cse_file_req_s file_req,
  input wire logic [cse_pkg::DATA_W-1:0] file_rdata,
  // watchdog clears
  output logic watchdog_counter_clr,
  output logic watchdog_prescaler_clr
);
  import cse_pkg::*;
  localparam int SW = $clog2(STACK_DEPTH) + 1;

  cse_state_e state_q; // sequencer state
  cse_instr_s instr_q; // instruction in flight
  logic discard_q; // instruction in flight is skipped
  logic skip_q; // next issued instruction is skipped
  logic [DATA_W-1:0] opnd_q; // file register operand
  logic [DATA_W-1:0] work_q; // working register
  logic zero_q; // zero flag
  logic timeout_flag_n_q; // timeout flag, active low
  logic powerdown_flag_n_q; // powerdown flag, active low
  logic [LATCH_W-1:0] pc_high_latch_q; // pc high latch
  logic [PC_W-1:0] pc_q; // address of current instruction
  cse_file_req_s file_req_q; // file register request
  logic wdt_clr_q; // watchdog clear pulse
  logic [APB_DW-1:0] prdata_q; // read data
  cse_alu_s alu_o; // datapath verdict
  logic stk_push; // push return address
  logic [PC_W-1:0] stack_top; // top of return stack
  logic [SW-1:0] stk_cnt; // stack fill
  logic [APB_DW-1:0] rd_val; // read mux
  logic addr_ok; // mapped address
  logic is_instr; // instruction register hit
  logic acc; // access phase
  logic wr_en; // write completes this edge
  logic issue; // instruction accepted this edge
  logic exec_live; // non-discarded execute cycle
  logic is_call; // call via work in execute

  // apb decode
  assign is_instr = (paddr == ADDR_INSTR);
  assign addr_ok = is_instr || paddr == ADDR_WORK || paddr == ADDR_STATUS
    || paddr == ADDR_LATCH || paddr == ADDR_PC || paddr == ADDR_STACK;
  assign acc = psel && penable;
  // an instruction write waits until the sequencer is idle
  assign pready = !(psel && pwrite && is_instr && state_q != st_idle);
  assign pslverr = acc && !addr_ok;
  assign wr_en = acc && pready && pwrite && addr_ok;
  assign issue = wr_en && is_instr;
  assign exec_live = (state_q == st_exec) && !discard_q;
  assign is_call = exec_live && instr_q.op == call_via_work_reg_op;

  // datapath
  cse_alu u_alu (
    .op(instr_q.op),
    .dest(instr_q.dest),
    .fdata(opnd_q),
    .res(alu_o)
  );

  // return stack, pushed during the execute cycle
  assign stk_push = is_call;
  cse_ret_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(stk_push),
    .push_data(PC_W'(pc_q + PC_STEP)),
    .top(stack_top),
    .count(stk_cnt)
  );

  // sequencer: accept, read operand, execute, second call cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      instr_q <= '0;
      discard_q <= 1'b0;
    end else begin
      case (state_q)
        st_idle: begin
          if (issue) begin
            instr_q.op <= cse_op_e'(pwdata[INSTR_OP_LSB +: OP_W]);
            instr_q.faddr <= pwdata[INSTR_F_LSB +: FADDR_W];
            instr_q.dest <= pwdata[INSTR_D_BIT];
            discard_q <= skip_q;
            state_q <= st_read;
          end
        end
        st_read: begin
          state_q <= st_exec;
        end
        st_exec: begin
          // call takes a second cycle
          state_q <= is_call ? st_second : st_idle;
        end
        st_second: begin
          state_q <= st_idle;
        end
        default: begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // operand capture in the read cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_q <= DATA_ZERO;
    end else if (state_q == st_read) begin
      opnd_q <= file_rdata;
    end
  end

  // skip request: set by a zero decrement-skip result, consumed by next issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
    end else if (exec_live && alu_o.skip) begin
      skip_q <= 1'b1;
    end else if (issue) begin
      skip_q <= 1'b0;
    end
  end

  // file register request, write pulse after execute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_req_q <= '0;
    end else begin
      if (issue) begin
        file_req_q.addr <= pwdata[INSTR_F_LSB +: FADDR_W];
      end
      file_req_q.we <= exec_live && alu_o.wr_file;
      if (exec_live && alu_o.wr_file) begin
        file_req_q.wdata <= alu_o.result;
      end
    end
  end

  // working register, execute wins over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_q <= WORK_RST;
    end else if (exec_live && alu_o.wr_work) begin
      work_q <= alu_o.result;
    end else if (wr_en && paddr == ADDR_WORK) begin
      work_q <= pwdata[DATA_W-1:0];
    end
  end

  // zero flag, execute wins over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_q <= Z_RST;
    end else if (exec_live && alu_o.upd_z) begin
      zero_q <= alu_o.zero;
    end else if (wr_en && paddr == ADDR_STATUS) begin
      zero_q <= pwdata[STS_Z_BIT];
    end
  end

  // timeout and powerdown flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_n_q <= FLAG_N_RST;
      powerdown_flag_n_q <= FLAG_N_RST;
    end else if (exec_live && instr_q.op == watchdog_clear_op) begin
      timeout_flag_n_q <= 1'b1;
      powerdown_flag_n_q <= 1'b1;
    end else if (wr_en && paddr == ADDR_STATUS) begin
      timeout_flag_n_q <= pwdata[STS_TO_BIT];
      powerdown_flag_n_q <= pwdata[STS_PD_BIT];
    end
  end

  // watchdog clear strobe drives both clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_clr_q <= 1'b0;
    end else begin
      wdt_clr_q <= exec_live && instr_q.op == watchdog_clear_op;
    end
  end

  // pc high latch, software only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_high_latch_q <= LATCH_RST;
    end else if (wr_en && paddr == ADDR_LATCH) begin
      pc_high_latch_q <= pwdata[LATCH_W-1:0];
    end
  end

  // program counter: step, or branch in the second call cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= PC_RST;
    end else if (state_q == st_second) begin
      pc_q <= {pc_high_latch_q, work_q};
    end else if (state_q == st_exec && !is_call) begin
      pc_q <= PC_W'(pc_q + PC_STEP);
    end else if (wr_en && paddr == ADDR_PC) begin
      pc_q <= pwdata[PC_W-1:0];
    end
  end

  // read mux
  always_comb begin
    rd_val = '0;
    case (paddr)
      ADDR_INSTR: begin
        rd_val[INSTR_OP_LSB +: OP_W] = instr_q.op;
        rd_val[INSTR_F_LSB +: FADDR_W] = instr_q.faddr;
        rd_val[INSTR_D_BIT] = instr_q.dest;
      end
      ADDR_WORK: rd_val[DATA_W-1:0] = work_q;
      ADDR_STATUS: begin
        rd_val[STS_Z_BIT] = zero_q;
        rd_val[STS_PD_BIT] = powerdown_flag_n_q;
        rd_val[STS_TO_BIT] = timeout_flag_n_q;
        rd_val[STS_BUSY_BIT] = (state_q != st_idle);
        rd_val[STS_SKIP_BIT] = skip_q;
      end
      ADDR_LATCH: rd_val[LATCH_W-1:0] = pc_high_latch_q;
      ADDR_PC: rd_val[PC_W-1:0] = pc_q;
      ADDR_STACK: begin
        rd_val[PC_W-1:0] = stack_top;
        rd_val[STK_CNT_LSB +: SW] = stk_cnt;
      end
      default: rd_val = '0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_val;
    end
  end

  assign prdata = prdata_q;
  assign file_req = file_req_q;
  assign watchdog_counter_clr = wdt_clr_q;
  assign watchdog_prescaler_clr = wdt_clr_q;

  // checks
  a_wdt_clear_pair: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && instr_q.op == watchdog_clear_op)
      |=> watchdog_counter_clr && watchdog_prescaler_clr ##1 !watchdog_counter_clr)
    else $error("watchdog clears not a joint pulse");
  a_wdt_flags_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && instr_q.op == watchdog_clear_op)
      |=> timeout_flag_n_q && powerdown_flag_n_q && $stable(zero_q))
    else $error("watchdog clear flags wrong");
  a_call_push_first: assert property (
    @(posedge pclk) disable iff (!presetn)
    is_call |=> stack_top == PC_W'($past(pc_q) + PC_STEP) && $stable(pc_q))
    else $error("return address not pushed before branch");
  a_call_target: assert property (
    @(posedge pclk) disable iff (!presetn)
    is_call |-> ##2 pc_q == {$past(pc_high_latch_q), $past(work_q)})
    else $error("call target wrong");
  a_call_two_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (is_call && !(wr_en && paddr == ADDR_STATUS))
      |=> state_q == st_second && $stable(zero_q) && $stable(timeout_flag_n_q)
      ##1 state_q == st_idle)
    else $error("call timing or flags wrong");
  a_comp_to_file: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && instr_q.op == complement_file_op && instr_q.dest)
      |=> file_req.we && file_req.wdata == ~$past(opnd_q)
      && zero_q == (~$past(opnd_q) == DATA_ZERO))
    else $error("complement result wrong");
  a_dest_to_work: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && !instr_q.dest && (instr_q.op == complement_file_op
      || instr_q.op == decrement_file_op || instr_q.op == decrement_skip_zero_op))
      |=> !file_req.we && work_q == $past(alu_o.result))
    else $error("destination routing wrong");
  a_clear_file: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && instr_q.op == clear_file_op)
      |=> file_req.we && file_req.wdata == DATA_ZERO && zero_q)
    else $error("clear file wrong");
  a_clear_work: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && instr_q.op == clear_work_reg_op) |=> work_q == DATA_ZERO && zero_q)
    else $error("clear work wrong");
  a_dec_zero_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && instr_q.op == decrement_file_op)
      |=> zero_q == ($past(opnd_q) == DATA_ONE))
    else $error("decrement zero flag wrong");
  a_dskip_no_flags: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && instr_q.op == decrement_skip_zero_op && !(wr_en && paddr == ADDR_STATUS))
      |=> $stable(zero_q) && $stable(timeout_flag_n_q) && $stable(powerdown_flag_n_q))
    else $error("decrement skip touched flags");
  a_dskip_skips: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && instr_q.op == decrement_skip_zero_op)
      |=> skip_q == ($past(opnd_q) == DATA_ONE))
    else $error("skip decision wrong");
  a_dec_wraps: assert property (
    @(posedge pclk) disable iff (!presetn)
    (exec_live && instr_q.op == decrement_file_op && instr_q.dest && opnd_q == DATA_ZERO)
      |=> file_req.wdata == ~DATA_ZERO)
    else $error("decrement of zero did not wrap");
endmodule
`default_nettype wire

/* rtl/cse_pkg.sv */
`default_nettype none
package cse_pkg;
  // widths
  localparam int DATA_W = 8;
  localparam int PC_W = 15;
  localparam int LATCH_W = 7;
  localparam int FADDR_W = 7;
  localparam int OP_W = 4;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int STACK_DEPTH = 16;
  // register byte addresses
  localparam logic [APB_AW-1:0] ADDR_INSTR = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_WORK = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_LATCH = 8'h0C;
  localparam logic [APB_AW-1:0] ADDR_PC = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_STACK = 8'h14;
  // instruction word fields
  localparam int INSTR_OP_LSB = 0;
  localparam int INSTR_F_LSB = 8;
  localparam int INSTR_D_BIT = 16;
  // status word bits
  localparam int STS_Z_BIT = 0;
  localparam int STS_PD_BIT = 1;
  localparam int STS_TO_BIT = 2;
  localparam int STS_BUSY_BIT = 3;
  localparam int STS_SKIP_BIT = 4;
  // stack word field
  localparam int STK_CNT_LSB = 16;
  // reset values and fixed data
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
  localparam logic Z_RST = 1'b0;
  localparam logic FLAG_N_RST = 1'b1;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  // instruction codes, numbered from zero in this order
  typedef enum logic [OP_W-1:0] {
    op_nop, watchdog_clear_op, call_via_work_reg_op, complement_file_op,
    clear_file_op, decrement_file_op, clear_work_reg_op, decrement_skip_zero_op
  } cse_op_e;
  // sequencer states
  typedef enum logic [1:0] {st_idle, st_read, st_exec, st_second} cse_state_e;
  // issued instruction
  typedef struct packed {
    logic dest;
    logic [FADDR_W-1:0] faddr;
    cse_op_e op;
  } cse_instr_s;
  // datapath verdict
  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic wr_file;
    logic wr_work;
    logic upd_z;
    logic zero;
    logic skip;
  } cse_alu_s;
  // request to the data register file
  typedef struct packed {
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
  } cse_file_req_s;
endpackage
`default_nettype wire

/* rtl/cse_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module cse_alu (
  // instruction and operands
  input wire cse_pkg::cse_op_e op,
  input wire logic dest,
  input wire logic [cse_pkg::DATA_W-1:0] fdata,
  // verdict
  output cse_pkg::cse_alu_s res
);
  import cse_pkg::*;

  // result, destination and flag effect per instruction
  always_comb begin
    res = '0;
    case (op)
      complement_file_op: begin
        res.result = ~fdata;
        res.upd_z = 1'b1;
        res.wr_file = dest;
        res.wr_work = ~dest;
      end
      clear_file_op: begin
        res.result = DATA_ZERO;
        res.upd_z = 1'b1;
        res.wr_file = 1'b1;
      end
      decrement_file_op: begin
        res.result = DATA_W'(fdata - DATA_ONE);
        res.upd_z = 1'b1;
        res.wr_file = dest;
        res.wr_work = ~dest;
      end
      clear_work_reg_op: begin
        res.result = DATA_ZERO;
        res.upd_z = 1'b1;
        res.wr_work = 1'b1;
      end
      decrement_skip_zero_op: begin
        res.result = DATA_W'(fdata - DATA_ONE);
        res.wr_file = dest;
        res.wr_work = ~dest;
        res.skip = (DATA_W'(fdata - DATA_ONE) == DATA_ZERO);
      end
      default: begin
        res.result = DATA_ZERO;
      end
    endcase
    // zero follows the eight-bit result
    res.zero = (res.result == DATA_ZERO);
  end
endmodule
`default_nettype wire

/* rtl/cse_ret_stack.sv */
`timescale 1ns/1ps
`default_nettype none
module cse_ret_stack #(
  parameter int DEPTH = cse_pkg::STACK_DEPTH,
  parameter int WIDTH = cse_pkg::PC_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // push side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // view of the top entry
  output logic [WIDTH-1:0] top,
  output logic [$clog2(DEPTH):0] count
);
  import cse_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH]; // return addresses
  logic [PW-1:0] ptr_q; // next free slot, wraps like a ring
  logic [PW:0] cnt_q; // filled entries, saturating
  logic [PW-1:0] prev; // slot of the top entry

  // entry storage, no reset needed
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[ptr_q] <= push_data;
    end
  end

  // write pointer, overflow overwrites the oldest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= '0;
    end else if (push) begin
      ptr_q <= (ptr_q == LAST) ? '0 : PW'(ptr_q + 1'b1);
    end
  end

  // fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (push && cnt_q != (PW+1)'(DEPTH)) begin
      cnt_q <= (PW+1)'(cnt_q + 1'b1);
    end
  end

  assign prev = (ptr_q == '0) ? LAST : PW'(ptr_q - 1'b1);
  // empty stack shows zero
  assign top = (cnt_q == '0) ? '0 : mem_q[prev];
  assign count = cnt_q;
endmodule
`default_nettype wire

/* dv/cse_file_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cse_file_model (
  // clock
  input wire logic pclk,
  // request from the core
  input wire cse_pkg::cse_file_req_s file_req,
  // read data back to the core
  output logic [cse_pkg::DATA_W-1:0] file_rdata
);
  import cse_pkg::*;
  // register contents, preloaded by the bench
  logic [DATA_W-1:0] mem [128];
  // read follows the address within the same cycle
  assign file_rdata = mem[file_req.addr];
  // one-cycle write pulse stores the result
  always @(posedge pclk) begin
    if (file_req.we === 1'b1) begin
      mem[file_req.addr] <= file_req.wdata;
    end
  end
endmodule
`default_nettype wire

/* dv/core_subset_instruction_execute_test.sv */
`timescale 1ns/1ps
`default_nettype none
module core_subset_instruction_execute_test;
  import cse_pkg::*;
  // apb and core signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wdt_clr, pre_clr, err;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd, r;
  cse_file_req_s file_req;
  logic [DATA_W-1:0] file_rdata;
  // scoreboard state
  int err_total, checks, wdt_seen, wdt_exp, w, z, to, pd, latch, pc, skp;
  int mem_m[128];
  int stk[$];
  logic [31:0] lfsr = 32'h155336D5;

  cse_core_exec i_cse_core_exec (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .file_req(file_req), .file_rdata(file_rdata),
    .watchdog_counter_clr(wdt_clr), .watchdog_prescaler_clr(pre_clr));
  cse_file_model i_cse_file_model (.pclk(pclk), .file_req(file_req), .file_rdata(file_rdata));

  // free-running clock, 8 ns
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // pseudo-random source
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog clears must pulse together
  always @(posedge pclk) begin
    chk("wdt_pair", 32'(pre_clr), 32'(wdt_clr));
    if (wdt_clr === 1'b1) wdt_seen++;
  end

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic erv);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      n++;
      if (n > 50) begin
        err_total++;
        final_report();
      end
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reference execution of one instruction
  task automatic model(input int op, input int f, input int d);
    int res;
    res = 0;
    if (skp != 0) begin
      skp = 0;
      pc = (pc + 1) % 32768;
      return;
    end
    case (op)
      1: begin
        to = 1;
        pd = 1;
        wdt_exp++;
      end
      2: begin
        // ring of fixed depth: a full stack loses its oldest entry
        if (stk.size() == STACK_DEPTH) void'(stk.pop_front());
        stk.push_back((pc + 1) % 32768);
        pc = latch * 256 + w;
        return;
      end
      3: res = ~mem_m[f] & 255;
      4: begin
        mem_m[f] = 0;
        z = 1;
      end
      5, 7: res = (mem_m[f] + 255) % 256;
      6: begin
        w = 0;
        z = 1;
      end
      default: ;
    endcase
    if (op == 3 || op == 5 || op == 7) begin
      if (d != 0) mem_m[f] = res;
      else w = res;
      if (op != 7) z = (res == 0);
      else skp = (res == 0);
    end
    pc = (pc + 1) % 32768;
  endtask

  // issue an instruction and step the reference
  task automatic issue(input int op, input int f, input int d);
    apb(1'b1, ADDR_INSTR, 32'(d * 65536 + f * 256 + op), rd, err);
    model(op, f, d);
  endtask

  // poll busy until clear
  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
      if (rd[STS_BUSY_BIT] === 1'b0) return;
    end
    err_total++;
    final_report();
  endtask

  // compare visible state with the reference
  task automatic cmp_all(input int f);
    apb(1'b0, ADDR_WORK, 32'h0, rd, err);
    chk("work", rd, 32'(w));
    apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
    chk("status", rd, 32'(skp * 16 + to * 4 + pd * 2 + z));
    apb(1'b0, ADDR_PC, 32'h0, rd, err);
    chk("pc", rd, 32'(pc));
    apb(1'b0, ADDR_LATCH, 32'h0, rd, err);
    chk("latch", rd, 32'(latch));
    apb(1'b0, ADDR_STACK, 32'h0, rd, err);
    chk("stack", rd, 32'(stk.size() * 65536 + (stk.size() > 0 ? stk[$] : 0)));
    chk("file", 32'(i_cse_file_model.mem[f]), 32'(mem_m[f]));
    chk("wdt_count", 32'(wdt_seen), 32'(wdt_exp));
  endtask

  // preload one file register in model and partner
  task automatic load(input int f, input int v);
    mem_m[f] = v;
    i_cse_file_model.mem[f] = 8'(v);
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    {err_total, checks, wdt_seen, wdt_exp, w, z, latch, pc, skp} = '0;
    to = 1;
    pd = 1;
    for (int a = 0; a < 128; a++) load(a, int'(rnd() & 32'hFF));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    cmp_all(0);
    // unmapped place: error, zero data, no effect
    apb(1'b0, 8'h40, 32'h0, rd, err);
    chk("slverr", 32'(err), 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'b1, 8'h40, 32'hFF, rd, err);
    chk("slverr_wr", 32'(err), 32'h1);
    // back to back: second issue finds the core idle, no pready stall
    issue(6, 0, 0);
    issue(3, 5, 0);
    wait_idle();
    cmp_all(5);
    // zero result of decrement-skip discards a watchdog clear
    load(3, 1);
    apb(1'b1, ADDR_STATUS, 32'h0, rd, err);
    {to, pd, z} = '0;
    issue(7, 3, 1);
    wait_idle();
    cmp_all(3);
    issue(1, 0, 0);
    wait_idle();
    cmp_all(3);
    // decrement of zero wraps, then a live watchdog clear, then a call
    load(9, 0);
    issue(5, 9, 1);
    wait_idle();
    cmp_all(9);
    issue(1, 0, 0);
    wait_idle();
    cmp_all(9);
    w = 32'hA5;
    latch = 32'h5A;
    apb(1'b1, ADDR_WORK, 32'(w), rd, err);
    apb(1'b1, ADDR_LATCH, 32'(latch), rd, err);
    issue(2, 0, 0);
    wait_idle();
    cmp_all(9);
    // random instructions, operands and setup
    for (int k = 0; k < 60; k++) begin
      r = rnd();
      w = int'(rnd() & 32'hFF);
      apb(1'b1, ADDR_WORK, 32'(w), rd, err);
      z = int'(r[16]);
      pd = int'(r[17]);
      to = int'(r[18]);
      apb(1'b1, ADDR_STATUS, 32'(z + pd * 2 + to * 4), rd, err);
      latch = int'(rnd() & 32'h7F);
      apb(1'b1, ADDR_LATCH, 32'(latch), rd, err);
      pc = int'(rnd() & 32'h7FFF);
      apb(1'b1, ADDR_PC, 32'(pc), rd, err);
      if (r[21:20] == 2'b00) load(int'(r[6:0]), int'(r[22]));
      else if (r[21:20] == 2'b01) load(int'(r[6:0]), 255);
      issue(int'(r[11:8]), int'(r[6:0]), int'(r[7]));
      wait_idle();
      cmp_all(int'(r[6:0]));
    end
    // second reset in mid-run restores the core's visible registers, file registers keep their values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {w, z, latch, pc, skp} = '0;
    to = 1;
    pd = 1;
    stk.delete();
    cmp_all(0);
    final_report();
  end
endmodule
`default_nettype wire
